/* File: pkg/frs_pkg.sv */
package frs_pkg;

    // ----------------------------------------------------------------
    // register map (byte address = word index * 4)
    // ----------------------------------------------------------------
    localparam logic [4:0] FRS_OFF_ADDR_LOW  = 5'h00;
    localparam logic [4:0] FRS_OFF_ADDR_HIGH = 5'h04;
    localparam logic [4:0] FRS_OFF_DATA_LOW  = 5'h08;
    localparam logic [4:0] FRS_OFF_DATA_HIGH = 5'h0c;
    localparam logic [4:0] FRS_OFF_CONTROL   = 5'h10;
    localparam logic [4:0] FRS_OFF_UNLOCK    = 5'h14;

    // ----------------------------------------------------------------
    // control register fields
    // ----------------------------------------------------------------
    localparam int FRS_BIT_READ_START  = 0;
    localparam int FRS_BIT_WRITE_START = 1;
    localparam int FRS_BIT_WRITE_EN    = 2;
    localparam int FRS_BIT_WRITE_ERR   = 3;
    localparam int FRS_BIT_LATCH_ONLY  = 5;
    localparam int FRS_BIT_ERASE_SEL   = 4;
    localparam int FRS_BIT_CFG_SEL     = 6;

    // ----------------------------------------------------------------
    // unlock keys, blank value, geometry
    // ----------------------------------------------------------------
    localparam logic [7:0]  FRS_KEY_FIRST  = 8'h55;
    localparam logic [7:0]  FRS_KEY_SECOND = 8'haa;
    localparam logic [13:0] FRS_BLANK      = 14'h3fff;
    localparam int          FRS_LATCHES    = 32;
    localparam int          FRS_ROW_BITS   = 10;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int FRS_CLK_MHZ        = 125;
    localparam int FRS_ERASE_US       = 2000;
    localparam int FRS_ERASE_CYCLES   = FRS_ERASE_US * FRS_CLK_MHZ;
    localparam int FRS_SETUP_CYCLES   = 2;

    typedef enum logic [1:0] {
        FRS_UNL_IDLE,
        FRS_UNL_FIRST,
        FRS_UNL_ARMED
    } frs_unl_t;

    typedef enum logic [2:0] {
        FRS_ST_IDLE,
        FRS_ST_SETUP,
        FRS_ST_ERASE,
        FRS_ST_PROGRAM,
        FRS_ST_DONE
    } frs_state_t;

    typedef struct packed {
        logic        erase;
        logic        latch_only;
        logic [14:0] addr;
        logic [13:0] data;
    } frs_op_t;

endpackage

/* File: core/frs_flash_port.sv */
`timescale 1ns/10ps
module frs_flash_port
    import frs_pkg::*;
#(
    parameter int ROW_W = FRS_ROW_BITS
) (
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    input  wire logic             erase_in,
    input  wire logic             program_in,
    input  wire logic [ROW_W-1:0] row_in,
    output logic                  busy_out
);
    // ----------------------------------------------------------------
    // array operation marker; the array itself is outside
    // ----------------------------------------------------------------
    logic busy_d;
    logic busy_q;

    always_comb begin
        busy_d = busy_q;
        if (erase_in || program_in) begin
            busy_d = 1'b1;
        end else begin
            busy_d = 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            busy_q <= 1'b0;
        end else begin
            busy_q <= busy_d;
        end
    end

    assign busy_out = busy_q;
endmodule

/* File: core/frs_seq.sv */
// Implementation choices: the Avalon-MM slave port and the address map.
`timescale 1ns/10ps
// How it works
// - erase acts on whole row only
// - two setup cycles after write start
// - core stalled for erase duration
// - stall keeps clocks, no sleep
// - resume at third instruction afterwards
// - program never erases automatically
// - one to thirty-two words per program
// - upper ten bits row, low five latch
// - program confined to selected row
// - latches reset blank after each erase or program, kept after latch-only load
// - unloaded blank latches programmed blank
// - latch-only one loads latch only
// - latch-only zero loads then programs row
// - broken unlock does nothing
// - start bits cleared by hardware only
// - reset during erase or program sets error flag, not during setup
// - unlock register reads zero
module frs_seq
    import frs_pkg::*;
#(
    parameter int ERASE_CYCLES = FRS_ERASE_CYCLES,
    parameter int LATCHES      = FRS_LATCHES
) (
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    input  wire logic [4:0]  avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [31:0] avs_writedata_in,
    output logic [31:0]      avs_readdata_out,
    output logic             avs_waitrequest_out,
    output logic             core_stall_out,
    output logic             core_sleep_out,
    output logic             array_erase_out,
    output logic             array_program_out,
    output logic [9:0]       array_row_out,
    output logic [13:0]      array_word_out,
    output logic [4:0]       array_word_idx_out
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [7:0]  addr_low_q, addr_low_d;
    logic [6:0]  addr_high_q, addr_high_d;
    logic [7:0]  data_low_q, data_low_d;
    logic [5:0]  data_high_q, data_high_d;
    logic        wr_en_q, wr_en_d, erase_sel_q, erase_sel_d;
    logic        lonly_q, lonly_d, cfg_q, cfg_d;
    logic        wstart_q, wstart_d, rstart_q, rstart_d;
    logic        werr_q, werr_d, inflight_q;
    frs_unl_t    unl_q, unl_d;
    frs_state_t  st_q, st_d;
    frs_op_t     op_q, op_d;
    logic [1:0]  setup_q, setup_d;
    logic [17:0] cnt_q, cnt_d;
    logic [4:0]  widx_q, widx_d;
    logic [13:0] latch_q [LATCHES];
    logic        ack_q, ack_d;
    logic [31:0] rdata_q, rdata_d;
    logic        stall_q, stall_d;
    logic        aer_q, aer_d, apg_q, apg_d;
    logic [9:0]  arow_q, arow_d;
    logic [13:0] aword_q, aword_d;
    logic [4:0]  aidx_q, aidx_d;
    logic        req, wr_ctl, wr_unl, fire, latch_ld, latch_clr;

    function automatic logic [9:0] row_of(input logic [6:0] hi, input logic [7:0] lo);
        row_of = {hi, lo[7:5]};
    endfunction

    assign req    = (avs_read_in || avs_write_in) && !ack_q;
    assign wr_ctl = req && avs_write_in && avs_address_in == FRS_OFF_CONTROL;
    assign wr_unl = req && avs_write_in && avs_address_in == FRS_OFF_UNLOCK;

    // ----------------------------------------------------------------
    // bus, unlock and sequencer
    // ----------------------------------------------------------------
    always_comb begin
        addr_low_d  = addr_low_q;
        addr_high_d = addr_high_q;
        data_low_d  = data_low_q;
        data_high_d = data_high_q;
        wr_en_d     = wr_en_q;
        erase_sel_d = erase_sel_q;
        lonly_d     = lonly_q;
        cfg_d       = cfg_q;
        wstart_d    = wstart_q;
        rstart_d    = 1'b0;
        werr_d      = werr_q;
        unl_d       = unl_q;
        st_d        = st_q;
        op_d        = op_q;
        setup_d     = setup_q;
        cnt_d       = cnt_q;
        widx_d      = widx_q;
        ack_d       = req;
        rdata_d     = 32'h0000_0000;
        stall_d     = 1'b0;
        aer_d       = 1'b0;
        apg_d       = 1'b0;
        arow_d      = arow_q;
        aword_d     = aword_q;
        aidx_d      = aidx_q;
        fire        = 1'b0;
        latch_ld    = 1'b0;
        latch_clr   = 1'b0;
        if (req && avs_write_in) begin
            case (avs_address_in)
                FRS_OFF_ADDR_LOW:  addr_low_d  = avs_writedata_in[7:0];
                FRS_OFF_ADDR_HIGH: addr_high_d = avs_writedata_in[6:0];
                FRS_OFF_DATA_LOW:  data_low_d  = avs_writedata_in[7:0];
                FRS_OFF_DATA_HIGH: data_high_d = avs_writedata_in[5:0];
                FRS_OFF_CONTROL: begin
                    wr_en_d     = avs_writedata_in[FRS_BIT_WRITE_EN];
                    erase_sel_d = avs_writedata_in[FRS_BIT_ERASE_SEL];
                    lonly_d     = avs_writedata_in[FRS_BIT_LATCH_ONLY];
                    cfg_d       = avs_writedata_in[FRS_BIT_CFG_SEL];
                    werr_d      = werr_q & avs_writedata_in[FRS_BIT_WRITE_ERR];
                    rstart_d    = avs_writedata_in[FRS_BIT_READ_START];
                end
                default: ;
            endcase
        end
        if (wr_unl) begin
            if (avs_writedata_in[7:0] == FRS_KEY_FIRST) begin
                unl_d = FRS_UNL_FIRST;
            end else if (avs_writedata_in[7:0] == FRS_KEY_SECOND && unl_q == FRS_UNL_FIRST) begin
                unl_d = FRS_UNL_ARMED;
            end else begin
                unl_d = FRS_UNL_IDLE;
            end
        end else if (req && avs_write_in) begin
            unl_d = FRS_UNL_IDLE;
        end
        if (wr_ctl && avs_writedata_in[FRS_BIT_WRITE_START] && st_q == FRS_ST_IDLE && unl_q == FRS_UNL_ARMED
            && avs_writedata_in[FRS_BIT_WRITE_EN] && !avs_writedata_in[FRS_BIT_CFG_SEL]) begin
            fire     = 1'b1;
            wstart_d = 1'b1;
            unl_d    = FRS_UNL_IDLE;
            op_d.erase      = avs_writedata_in[FRS_BIT_ERASE_SEL];
            op_d.latch_only = avs_writedata_in[FRS_BIT_LATCH_ONLY];
            op_d.addr       = {addr_high_q, addr_low_q};
            op_d.data       = {data_high_q, data_low_q};
            st_d            = FRS_ST_SETUP;
            setup_d         = 2'(FRS_SETUP_CYCLES - 1);
        end
        case (st_q)
            FRS_ST_IDLE: ;
            FRS_ST_SETUP: begin
                stall_d = 1'b1;
                if (setup_q == 2'h0) begin
                    if (op_q.erase) begin
                        st_d  = FRS_ST_ERASE;
                        cnt_d = 18'(ERASE_CYCLES - 1);
                    end else begin
                        latch_ld = 1'b1;
                        if (op_q.latch_only) begin
                            st_d = FRS_ST_DONE;
                        end else begin
                            st_d   = FRS_ST_PROGRAM;
                            widx_d = 5'h00;
                        end
                    end
                end else begin
                    setup_d = setup_q - 2'h1;
                end
            end
            FRS_ST_ERASE: begin
                stall_d = 1'b1;
                aer_d   = 1'b1;
                arow_d  = row_of(op_q.addr[14:8], op_q.addr[7:0]);
                if (cnt_q == 18'h0) begin
                    st_d = FRS_ST_DONE;
                end else begin
                    cnt_d = cnt_q - 18'h1;
                end
            end
            FRS_ST_PROGRAM: begin
                stall_d = 1'b1;
                apg_d   = 1'b1;
                arow_d  = row_of(op_q.addr[14:8], op_q.addr[7:0]);
                aidx_d  = widx_q;
                aword_d = latch_q[widx_q];
                if (widx_q == 5'(LATCHES - 1)) begin
                    st_d = FRS_ST_DONE;
                end else begin
                    widx_d = widx_q + 5'h1;
                end
            end
            FRS_ST_DONE: begin
                latch_clr = !op_q.latch_only || op_q.erase;
                wstart_d  = 1'b0;
                st_d      = FRS_ST_IDLE;
            end
            default: st_d = FRS_ST_IDLE;
        endcase
        if (req && avs_read_in) begin
            case (avs_address_in)
                FRS_OFF_ADDR_LOW:  rdata_d = {24'h0, addr_low_q};
                FRS_OFF_ADDR_HIGH: rdata_d = {25'h0, addr_high_q};
                FRS_OFF_DATA_LOW:  rdata_d = {24'h0, data_low_q};
                FRS_OFF_DATA_HIGH: rdata_d = {26'h0, data_high_q};
                FRS_OFF_CONTROL:   rdata_d = {25'h0, cfg_q, lonly_q, erase_sel_q, werr_q, wr_en_q, wstart_q, rstart_q};
                default:           rdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            addr_low_q  <= 8'h00;
            addr_high_q <= 7'h00;
            data_low_q  <= 8'h00;
            data_high_q <= 6'h00;
            wr_en_q     <= 1'b0;
            erase_sel_q <= 1'b0;
            lonly_q     <= 1'b0;
            cfg_q       <= 1'b0;
            wstart_q    <= 1'b0;
            rstart_q    <= 1'b0;
            werr_q      <= werr_q | inflight_q;
            unl_q       <= FRS_UNL_IDLE;
            st_q        <= FRS_ST_IDLE;
            op_q        <= '0;
            setup_q     <= 2'h0;
            cnt_q       <= 18'h0;
            widx_q      <= 5'h00;
            ack_q       <= 1'b0;
            rdata_q     <= 32'h0000_0000;
            stall_q     <= 1'b0;
            aer_q       <= 1'b0;
            apg_q       <= 1'b0;
            arow_q      <= 10'h000;
            aword_q     <= FRS_BLANK;
            aidx_q      <= 5'h00;
        end else begin
            addr_low_q  <= addr_low_d;
            addr_high_q <= addr_high_d;
            data_low_q  <= data_low_d;
            data_high_q <= data_high_d;
            wr_en_q     <= wr_en_d;
            erase_sel_q <= erase_sel_d;
            lonly_q     <= lonly_d;
            cfg_q       <= cfg_d;
            wstart_q    <= wstart_d;
            rstart_q    <= rstart_d;
            werr_q      <= werr_d;
            unl_q       <= unl_d;
            st_q        <= st_d;
            op_q        <= op_d;
            setup_q     <= setup_d;
            cnt_q       <= cnt_d;
            widx_q      <= widx_d;
            ack_q       <= ack_d;
            rdata_q     <= rdata_d;
            stall_q     <= stall_d;
            aer_q       <= aer_d;
            apg_q       <= apg_d;
            arow_q      <= arow_d;
            aword_q     <= aword_d;
            aidx_q      <= aidx_d;
        end
    end

    // ----------------------------------------------------------------
    // reset-interrupt tracker, drops to zero one cycle after reset asserts
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        inflight_q <= rst_n_in && (st_q == FRS_ST_ERASE || st_q == FRS_ST_PROGRAM);
    end

    // ----------------------------------------------------------------
    // write latches
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        for (int i = 0; i < LATCHES; i++) begin
            if (!rst_n_in || latch_clr) begin
                latch_q[i] <= FRS_BLANK;
            end else if (latch_ld && op_q.addr[4:0] == 5'(i)) begin
                latch_q[i] <= op_q.data;
            end
        end
    end

    frs_flash_port #(.ROW_W (FRS_ROW_BITS)) u_port (
        .clk_in     (clk_in),
        .rst_n_in   (rst_n_in),
        .erase_in   (aer_q),
        .program_in (apg_q),
        .row_in     (arow_q),
        .busy_out   ()
    );

    assign avs_readdata_out    = rdata_q;
    assign avs_waitrequest_out = !ack_q;
    assign core_stall_out      = stall_q;
    assign core_sleep_out      = 1'b0;
    assign array_erase_out     = aer_q;
    assign array_program_out   = apg_q;
    assign array_row_out       = arow_q;
    assign array_word_out      = aword_q;
    assign array_word_idx_out  = aidx_q;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_unlock_reads_zero: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (req && avs_read_in && avs_address_in == FRS_OFF_UNLOCK) |=> avs_readdata_out == 32'h0)
        else $error("unlock register read not zero");
    a_broken_unlock: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (wr_ctl && unl_q != FRS_UNL_ARMED) |=> st_q == FRS_ST_IDLE || $past(st_q) != FRS_ST_IDLE)
        else $error("operation started without unlock");
    a_setup_two: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        fire |=> st_q == FRS_ST_SETUP ##1 st_q == FRS_ST_SETUP ##1 st_q != FRS_ST_SETUP)
        else $error("setup not two cycles");
    a_stall_erase: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        st_q == FRS_ST_ERASE |=> core_stall_out)
        else $error("core not stalled in erase");
    a_no_sleep: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        core_stall_out |-> !core_sleep_out)
        else $error("stall entered sleep");
    a_start_clear: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        st_q == FRS_ST_DONE |=> !wstart_q)
        else $error("write start not cleared");
    a_latch_only: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (st_q == FRS_ST_SETUP && setup_q == 2'h0 && !op_q.erase && op_q.latch_only)
        |=> st_q == FRS_ST_DONE ##1 !array_program_out)
        else $error("latch load started programming");
    a_row_fixed: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (array_program_out && $past(array_program_out)) |-> $stable(array_row_out))
        else $error("program crossed row");
    a_latch_blank: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (st_q == FRS_ST_DONE && !op_q.latch_only) |=> latch_q[0] == FRS_BLANK)
        else $error("latches not blank after operation");
endmodule

/* File: test/frs_seq_tb.sv */
`timescale 1ns/10ps
module frs_seq_tb;
    import frs_pkg::*;
    // ----------------------------------------------------------------
    // signals and bookkeeping
    // ----------------------------------------------------------------
    localparam int          ERASE_N = 20;
    localparam logic [31:0] C_EN    = 32'h1 << FRS_BIT_WRITE_EN;
    localparam logic [31:0] C_ERS   = 32'h1 << FRS_BIT_ERASE_SEL;
    localparam logic [31:0] C_LO    = 32'h1 << FRS_BIT_LATCH_ONLY;
    localparam logic [31:0] C_GO    = 32'h1 << FRS_BIT_WRITE_START;
    localparam logic [31:0] C_CFG   = 32'h1 << FRS_BIT_CFG_SEL;
    logic        clk;
    logic        rst_n;
    logic [4:0]  adr;
    logic        rd;
    logic        wr;
    logic [31:0] wdat;
    logic [31:0] rdat;
    logic        wait_rq;
    logic        stall;
    logic        sleep;
    logic        erase;
    logic        prog;
    logic [9:0]  row;
    logic [13:0] word;
    logic [4:0]  widx;
    logic [9:0]  row_exp;
    logic        started;
    logic [13:0] mem [32];
    int          mismatches;
    int          checks_done;
    int          pre_n;
    int          ers_n;
    int          prg_n;
    int          stl_n;
    int          slp_n;
    int          row_bad;

    frs_seq #(.ERASE_CYCLES(ERASE_N)) frs_seq_i (
        .clk_in              (clk),
        .rst_n_in            (rst_n),
        .avs_address_in      (adr),
        .avs_read_in         (rd),
        .avs_write_in        (wr),
        .avs_writedata_in    (wdat),
        .avs_readdata_out    (rdat),
        .avs_waitrequest_out (wait_rq),
        .core_stall_out      (stall),
        .core_sleep_out      (sleep),
        .array_erase_out     (erase),
        .array_program_out   (prog),
        .array_row_out       (row),
        .array_word_out      (word),
        .array_word_idx_out  (widx)
    );

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // ----------------------------------------------------------------
    // monitor of the array side
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        if (stall === 1'b1) begin
            stl_n++;
            if (!started && erase !== 1'b1 && prog !== 1'b1) pre_n++;
        end
        if (erase === 1'b1 || prog === 1'b1) started = 1'b1;
        if (erase === 1'b1) ers_n++;
        if (prog === 1'b1) begin
            prg_n++;
            mem[widx] = word;
        end
        if ((erase === 1'b1 || prog === 1'b1) && row !== row_exp) row_bad++;
        if (rst_n === 1'b1 && sleep !== 1'b0) slp_n++;
    end

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic clr;
        pre_n = 0; ers_n = 0; prg_n = 0; stl_n = 0; slp_n = 0; row_bad = 0;
        started = 1'b0;
        for (int i = 0; i < 32; i++) mem[i] = 14'h0000;
    endtask

    task automatic bus(input logic is_wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        adr  <= a;
        wdat <= d;
        wr   <= is_wr;
        rd   <= !is_wr;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wait_rq !== 1'b0 && n < 50);
        q = rdat;
        check("bus ack", {31'h0, wait_rq}, 32'h0);
        if (wait_rq !== 1'b0) finish_test;
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic set_ad(input logic [14:0] a, input logic [13:0] d);
        wr_reg(FRS_OFF_ADDR_LOW, {24'h0, a[7:0]});
        wr_reg(FRS_OFF_ADDR_HIGH, {25'h0, a[14:8]});
        wr_reg(FRS_OFF_DATA_LOW, {24'h0, d[7:0]});
        wr_reg(FRS_OFF_DATA_HIGH, {26'h0, d[13:8]});
    endtask

    task automatic run_op(input logic [14:0] a, input logic [13:0] d, input logic [31:0] c);
        int n;
        set_ad(a, d);
        wr_reg(FRS_OFF_UNLOCK, {24'h0, FRS_KEY_FIRST});
        wr_reg(FRS_OFF_UNLOCK, {24'h0, FRS_KEY_SECOND});
        wr_reg(FRS_OFF_CONTROL, c | C_GO);
        n = 0;
        while (stall !== 1'b1 && n < 8) begin
            @(posedge clk);
            n++;
        end
        check("stall rose", {31'h0, stall}, 32'h1);
        n = 0;
        while (stall !== 1'b0 && n < 1000) begin
            @(posedge clk);
            n++;
        end
        check("stall released", {31'h0, stall}, 32'h0);
        if (stall !== 1'b0) finish_test;
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic test_regs;
        logic [31:0] q;
        bus(1'b0, FRS_OFF_UNLOCK, 32'h0, q);
        check("unlock read", q, 32'h0);
        bus(1'b0, 5'h18, 32'h0, q);
        check("unmapped read", q, 32'h0);
        wr_reg(FRS_OFF_CONTROL, C_EN | C_LO | 32'h1);
        bus(1'b0, FRS_OFF_CONTROL, 32'h0, q);
        check("control start bits", q & 32'h3, 32'h0);
        check("control readback", q & 32'h77, C_EN | C_LO);
        $display("test regs done");
    endtask

    task automatic test_erase;
        logic [31:0] q;
        clr;
        row_exp = 10'h152;
        run_op({row_exp, 5'h17}, 14'h0000, C_EN | C_ERS);
        check("erase cycles", ers_n, ERASE_N);
        check("setup cycles", pre_n, FRS_SETUP_CYCLES);
        check("stall bounded", stl_n, ERASE_N + FRS_SETUP_CYCLES);
        check("no sleep", slp_n, 0);
        check("erase row", row_bad, 0);
        check("erase no program", prg_n, 0);
        bus(1'b0, FRS_OFF_CONTROL, 32'h0, q);
        check("start cleared", {31'h0, q[FRS_BIT_WRITE_START]}, 32'h0);
        $display("test erase done");
    endtask

    task automatic test_program;
        logic [14:0] base;
        base = 15'h1b40;
        row_exp = base[14:5];
        clr;
        run_op(base + 15'd3, 14'h1234, C_EN | C_LO);
        run_op(base + 15'd31, 14'h2a5c, C_EN | C_LO);
        check("latch only", prg_n, 0);
        run_op(base, 14'h0abc, C_EN);
        check("program words", prg_n, FRS_LATCHES);
        check("program row", row_bad, 0);
        check("no erase", ers_n, 0);
        for (int i = 0; i < 32; i++)
            check("row word", mem[i], (i == 0) ? 14'h0abc : (i == 3) ? 14'h1234 :
                  (i == 31) ? 14'h2a5c : FRS_BLANK);
        clr;
        run_op(base + 15'd5, 14'h0155, C_EN);
        for (int i = 0; i < 32; i++)
            check("blank after op", mem[i], (i == 5) ? 14'h0155 : FRS_BLANK);
        $display("test program done");
    endtask

    task automatic test_reset;
        logic [31:0] q;
        set_ad(15'h0400, 14'h0000);
        wr_reg(FRS_OFF_UNLOCK, {24'h0, FRS_KEY_FIRST});
        wr_reg(FRS_OFF_UNLOCK, {24'h0, FRS_KEY_SECOND});
        wr_reg(FRS_OFF_CONTROL, C_EN | C_ERS | C_GO);
        repeat (8) @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        bus(1'b0, FRS_OFF_CONTROL, 32'h0, q);
        check("error flag", {31'h0, q[FRS_BIT_WRITE_ERR]}, 32'h1);
        check("start after reset", {31'h0, q[FRS_BIT_WRITE_START]}, 32'h0);
        wr_reg(FRS_OFF_CONTROL, 32'h0);
        bus(1'b0, FRS_OFF_CONTROL, 32'h0, q);
        check("error cleared", {31'h0, q[FRS_BIT_WRITE_ERR]}, 32'h0);
        $display("test reset done");
    endtask

    task automatic test_broken;
        clr;
        for (int k = 0; k < 5; k++) begin
            if (k != 0) wr_reg(FRS_OFF_UNLOCK, {24'h0, FRS_KEY_FIRST});
            if (k == 1) wr_reg(FRS_OFF_ADDR_LOW, 32'h0);
            if (k != 2) wr_reg(FRS_OFF_UNLOCK, {24'h0, FRS_KEY_SECOND});
            wr_reg(FRS_OFF_CONTROL, (k == 3) ? (C_EN | C_CFG | C_GO) : (k == 4) ? C_GO : (C_EN | C_GO));
            repeat (10) @(posedge clk);
        end
        check("broken stall", stl_n, 0);
        check("broken program", prg_n + ers_n, 0);
        $display("test broken unlock done");
    endtask

    // ----------------------------------------------------------------
    // main sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        adr = 5'h00;
        rd = 1'b0;
        wr = 1'b0;
        wdat = 32'h0;
        row_exp = 10'h000;
        mismatches = 0;
        checks_done = 0;
        clr;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        test_regs;
        test_erase;
        test_program;
        test_reset;
        test_broken;
        finish_test;
    end

    initial begin
        repeat (20000) @(posedge clk);
        check("run finished", 32'h0, 32'h1);
        finish_test;
    end
endmodule
